// ---- hdl/scec_regs.svh ----
`ifndef SCEC_REGS_SVH
`define SCEC_REGS_SVH

// chain index inside the six-bit chain vectors
`define SCEC_CHAIN_RX1          0
`define SCEC_CHAIN_RX2          1
`define SCEC_CHAIN_TX1          2
`define SCEC_CHAIN_TX2          3
`define SCEC_CHAIN_OBS1         4
`define SCEC_CHAIN_OBS2         5
`define SCEC_NUM_CHAINS         6

// bit positions inside the pin options setting
`define SCEC_OPT_RXTX_PIN       0
`define SCEC_OPT_OBS_PIN        1
`define SCEC_OPT_OBS_SHARES_RX  2
`define SCEC_OPT_OBS_PATH_SEL   3
`define SCEC_OPT_SINGLE_OBS     4
`define SCEC_OPT_SINGLE_CHOICE  5
`define SCEC_PIN_OPTIONS_RESET  8'h00

// controller register addresses on the software port
`define SCEC_ADDR_CHSEL         4'h0
`define SCEC_ADDR_PINMODE       4'h1
`define SCEC_ADDR_DRIVE         4'h2
`define SCEC_ADDR_GPIO          4'h3
`define SCEC_ADDR_STATUS        4'h4

// field positions in the controller registers
`define SCEC_CHSEL_AUTO_OFF     8
`define SCEC_PINMODE_PAIR_LSB   8
`define SCEC_STATUS_ERR         0

// periodic observation release timing
`define SCEC_CLK_MHZ            10
`define SCEC_OBS_HOLD_US        1000
`define SCEC_OBS_GAP_US         500

`endif

// ---- hdl/scec_pkg.sv ----
package scec_pkg;

  typedef enum logic [2:0] {
    receive_side_off = 3'h0,
    rx_one           = 3'h1,
    rx_two           = 3'h2,
    rx_both          = 3'h3,
    obs_one          = 3'h4,
    obs_two          = 3'h5,
    obs_both         = 3'h6
  } scec_rx_sel_t;

  typedef enum logic [1:0] {
    transmit_side_off = 2'h0,
    tx_one            = 2'h1,
    tx_two            = 2'h2,
    tx_both           = 2'h3
  } scec_tx_sel_t;

  typedef enum logic [1:0] {
    obs_gpio_pair_option_one   = 2'h0,
    obs_gpio_pair_option_two   = 2'h1,
    obs_gpio_pair_option_three = 2'h2,
    obs_gpio_pair_none         = 2'h3
  } scec_gpio_pair_t;

  typedef enum logic [1:0] {
    variant_full       = 2'h0,
    variant_rx_only    = 2'h1,
    variant_txobs_only = 2'h2
  } scec_variant_t;

  typedef enum logic [2:0] {
    obs_idle_st = 3'b001,
    obs_hold_st = 3'b010,
    obs_gap_st  = 3'b100
  } scec_obs_state_t;

endpackage

// ---- hdl/scec_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface scec_if;
  // channel-select command
  logic                   chsel_valid;
  scec_pkg::scec_rx_sel_t cmd_rx_sel;
  scec_pkg::scec_tx_sel_t cmd_tx_sel;
  // pin-mode command
  logic                      pinmode_valid;
  logic [7:0]                pin_options_setting;
  scec_pkg::scec_gpio_pair_t obs_gpio_pair_selection;
  // enable pins
  logic                   receiver_one_enable_in;
  logic                   receiver_two_enable_in;
  logic                   transmitter_one_enable_in;
  logic                   transmitter_two_enable_in;
  logic                   observation_one_enable_in;
  logic                   observation_two_enable_in;
  logic [9:0]             gpio_in;

  modport host (
    output chsel_valid,
    output cmd_rx_sel,
    output cmd_tx_sel,
    output pinmode_valid,
    output pin_options_setting,
    output obs_gpio_pair_selection,
    output receiver_one_enable_in,
    output receiver_two_enable_in,
    output transmitter_one_enable_in,
    output transmitter_two_enable_in,
    output observation_one_enable_in,
    output observation_two_enable_in,
    output gpio_in
  );

  modport dev (
    input chsel_valid,
    input cmd_rx_sel,
    input cmd_tx_sel,
    input pinmode_valid,
    input pin_options_setting,
    input obs_gpio_pair_selection,
    input receiver_one_enable_in,
    input receiver_two_enable_in,
    input transmitter_one_enable_in,
    input transmitter_two_enable_in,
    input observation_one_enable_in,
    input observation_two_enable_in,
    input gpio_in
  );
endinterface
`default_nettype wire

// ---- hdl/scec_device.sv ----
// Functional notes
// - channel select enables exactly the requested chains
// - software enables persist until next channel select
// - controller periodically returns receive side off
// - receive-only variant: transmit off, no observation
// - transmit/observation variant: never request receivers
// - pin control: chain follows its enable level
// - full variant takes observation enables from GPIO pair
// - pin-mode command sets pin control and pair
// - rxtx flag: receivers, transmitters follow dedicated pins
// - observation flag: observation chains follow observation inputs
// - observation may reuse receiver pins, reduced variant only
// - path select 0 observes one, 1 two
// - single observation input gates software-selected path
// - further setting picks the single enable input
// - pair selection: option one, two, three or none
// - reduced variants select no GPIO pair
// - options OR-combined, exactly one pair value
// - each chain enabled independently by own signal
// - prefer pin control for tightly aligned switching
`timescale 1ns/1ns
`include "scec_regs.svh"
`default_nettype none
module scec_device (
  // clock, reset, enable
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // link from the controller
  scec_if.dev                            link,
  // chain enables to the signal chains
  output logic [`SCEC_NUM_CHAINS-1:0]    chain_on_q,
  output logic                           obs_path_sel_q,
  // configuration readback
  output scec_pkg::scec_rx_sel_t         rx_sel_q,
  output scec_pkg::scec_tx_sel_t         tx_sel_q,
  output logic [7:0]                     pin_options_q,
  output scec_pkg::scec_gpio_pair_t      gpio_pair_q
);

  // software request per chain, ordered as the chain vector
  function automatic logic [`SCEC_NUM_CHAINS-1:0] scec_sw_decode(
    input scec_pkg::scec_rx_sel_t rx,
    input scec_pkg::scec_tx_sel_t tx
  );
    logic [`SCEC_NUM_CHAINS-1:0] v;
    v = '0;
    case (rx)
      scec_pkg::rx_one: begin
        v[`SCEC_CHAIN_RX1] = 1'b1;
      end
      scec_pkg::rx_two: begin
        v[`SCEC_CHAIN_RX2] = 1'b1;
      end
      scec_pkg::rx_both: begin
        v[`SCEC_CHAIN_RX1] = 1'b1;
        v[`SCEC_CHAIN_RX2] = 1'b1;
      end
      scec_pkg::obs_one: begin
        v[`SCEC_CHAIN_OBS1] = 1'b1;
      end
      scec_pkg::obs_two: begin
        v[`SCEC_CHAIN_OBS2] = 1'b1;
      end
      scec_pkg::obs_both: begin
        v[`SCEC_CHAIN_OBS1] = 1'b1;
        v[`SCEC_CHAIN_OBS2] = 1'b1;
      end
      default: begin
        v = v;
      end
    endcase
    v[`SCEC_CHAIN_TX1] = tx[0];
    v[`SCEC_CHAIN_TX2] = tx[1];
    return v;
  endfunction

  // first pin of a pair enables observation one, second enables two
  function automatic logic [1:0] scec_gpio_pick(
    input logic [9:0]                gpio,
    input scec_pkg::scec_gpio_pair_t pair
  );
    logic [1:0] p;
    p = 2'h0;
    case (pair)
      scec_pkg::obs_gpio_pair_option_one: begin
        p = {gpio[1], gpio[0]};
      end
      scec_pkg::obs_gpio_pair_option_two: begin
        p = {gpio[5], gpio[4]};
      end
      scec_pkg::obs_gpio_pair_option_three: begin
        p = {gpio[9], gpio[8]};
      end
      default: begin
        p = 2'h0;
      end
    endcase
    return p;
  endfunction

  logic [`SCEC_NUM_CHAINS-1:0] sw_level;
  logic [`SCEC_NUM_CHAINS-1:0] pin_level;
  logic [`SCEC_NUM_CHAINS-1:0] pin_ctl;
  logic [1:0]                  obs_src;
  logic                        single_gate;
  logic                        path_two;

  // the enable pins come from flops on this clock, so no synchroniser;
  // a pin change reaches its chain at the next edge
  // channel-select command; stays until the next one, no timeout
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_sel_q <= scec_pkg::receive_side_off;
      tx_sel_q <= scec_pkg::transmit_side_off;
    end else if (clk_en && link.chsel_valid) begin
      rx_sel_q <= link.cmd_rx_sel;
      tx_sel_q <= link.cmd_tx_sel;
    end
  end

  // pin-mode command: option flags and observation pair
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_options_q <= `SCEC_PIN_OPTIONS_RESET;
      gpio_pair_q   <= scec_pkg::obs_gpio_pair_none;
    end else if (clk_en && link.pinmode_valid) begin
      pin_options_q <= link.pin_options_setting;
      gpio_pair_q   <= link.obs_gpio_pair_selection;
    end
  end

  // decoded once, shared by all chains
  always_comb begin
    sw_level = scec_sw_decode(rx_sel_q, tx_sel_q);
  end

  // observation enable source: shared receiver pins, a gpio pair, or own inputs
  // shared receiver pins beat a gpio pair; the host keeps them apart
  always_comb begin
    if (pin_options_q[`SCEC_OPT_OBS_SHARES_RX]) begin
      obs_src = {link.receiver_two_enable_in, link.receiver_one_enable_in};
    end else if (gpio_pair_q != scec_pkg::obs_gpio_pair_none) begin
      obs_src = scec_gpio_pick(link.gpio_in, gpio_pair_q);
    end else begin
      obs_src = {link.observation_two_enable_in, link.observation_one_enable_in};
    end
  end

  // single observation input: one pin gates, software picks the path
  always_comb begin
    path_two    = pin_options_q[`SCEC_OPT_OBS_PATH_SEL];
    single_gate = pin_options_q[`SCEC_OPT_SINGLE_CHOICE] ? obs_src[1] : obs_src[0];
  end

  always_comb begin
    pin_level[`SCEC_CHAIN_RX1] = link.receiver_one_enable_in;
    pin_level[`SCEC_CHAIN_RX2] = link.receiver_two_enable_in;
    pin_level[`SCEC_CHAIN_TX1] = link.transmitter_one_enable_in;
    pin_level[`SCEC_CHAIN_TX2] = link.transmitter_two_enable_in;
    if (pin_options_q[`SCEC_OPT_SINGLE_OBS]) begin
      pin_level[`SCEC_CHAIN_OBS1] = single_gate & ~path_two;
      pin_level[`SCEC_CHAIN_OBS2] = single_gate & path_two;
    end else begin
      pin_level[`SCEC_CHAIN_OBS1] = obs_src[0];
      pin_level[`SCEC_CHAIN_OBS2] = obs_src[1];
    end
  end

  // option bits 6 and 7 are stored but steer nothing
  // which chains the pins own
  always_comb begin
    pin_ctl[`SCEC_CHAIN_RX1]  = pin_options_q[`SCEC_OPT_RXTX_PIN];
    pin_ctl[`SCEC_CHAIN_RX2]  = pin_options_q[`SCEC_OPT_RXTX_PIN];
    pin_ctl[`SCEC_CHAIN_TX1]  = pin_options_q[`SCEC_OPT_RXTX_PIN];
    pin_ctl[`SCEC_CHAIN_TX2]  = pin_options_q[`SCEC_OPT_RXTX_PIN];
    pin_ctl[`SCEC_CHAIN_OBS1] = pin_options_q[`SCEC_OPT_OBS_PIN];
    pin_ctl[`SCEC_CHAIN_OBS2] = pin_options_q[`SCEC_OPT_OBS_PIN];
  end

  // one flop per chain; a pin-owned chain never looks at the software value
  // per-chain flops keep each enable independent of the others
  genvar gi;
  generate
    for (gi = 0; gi < `SCEC_NUM_CHAINS; gi++) begin : g_chain
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          chain_on_q[gi] <= 1'b0;
        end else if (clk_en) begin
          chain_on_q[gi] <= pin_ctl[gi] ? pin_level[gi] : sw_level[gi];
        end
      end
    end
  endgenerate

  // path select is reported even outside the single-input option
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      obs_path_sel_q <= 1'b0;
    end else if (clk_en) begin
      obs_path_sel_q <= path_two;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/scec_host.sv ----
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "scec_regs.svh"
`default_nettype none
module scec_host #(
  parameter scec_pkg::scec_variant_t VARIANT     = scec_pkg::variant_full,
  parameter int unsigned             HOLD_CYCLES = `SCEC_OBS_HOLD_US * `SCEC_CLK_MHZ,
  parameter int unsigned             GAP_CYCLES  = `SCEC_OBS_GAP_US * `SCEC_CLK_MHZ
) (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // software port
  input  wire logic [3:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [31:0]      sw_rdata_q,
  // link to the device
  scec_if.host             link
);

  function automatic logic scec_chsel_ok(input logic [2:0] rx, input logic [1:0] tx);
    logic ok;
    ok = (rx <= 3'(scec_pkg::obs_both));
    if (VARIANT == scec_pkg::variant_rx_only) begin
      ok = ok && (tx == 2'(scec_pkg::transmit_side_off)) && (rx <= 3'(scec_pkg::rx_both));
    end else if (VARIANT == scec_pkg::variant_txobs_only) begin
      ok = ok && ((rx == 3'(scec_pkg::receive_side_off)) || (rx >= 3'(scec_pkg::obs_one)));
    end
    return ok;
  endfunction

  function automatic logic scec_pinmode_ok(input logic [7:0] opts, input logic [1:0] pair);
    logic ok;
    if (VARIANT == scec_pkg::variant_full) begin
      ok = !opts[`SCEC_OPT_OBS_SHARES_RX];
    end else begin
      ok = (pair == 2'(scec_pkg::obs_gpio_pair_none));
    end
    return ok;
  endfunction

  logic                      wr_chsel;
  logic                      wr_pin;
  logic                      chsel_ok;
  logic                      pin_ok;
  logic                      new_obs;
  logic                      hold_done;
  logic                      gap_done;
  logic                      auto_off_q;
  logic                      err_q;
  logic [5:0]                drive_q;
  logic [9:0]                gpio_q;
  logic [15:0]               cnt_q;
  scec_pkg::scec_rx_sel_t    req_rx_q;
  scec_pkg::scec_tx_sel_t    req_tx_q;
  scec_pkg::scec_obs_state_t state_q;

  always_comb begin
    wr_chsel  = sw_wr && (sw_addr == `SCEC_ADDR_CHSEL);
    wr_pin    = sw_wr && (sw_addr == `SCEC_ADDR_PINMODE);
    chsel_ok  = scec_chsel_ok(sw_wdata[2:0], sw_wdata[4:3]);
    pin_ok    = scec_pinmode_ok(sw_wdata[7:0], sw_wdata[`SCEC_PINMODE_PAIR_LSB+:2]);
    new_obs   = sw_wdata[`SCEC_CHSEL_AUTO_OFF] && (sw_wdata[2:0] >= 3'(scec_pkg::obs_one));
    hold_done = (state_q == scec_pkg::obs_hold_st) && (cnt_q == 16'h0000);
    gap_done  = (state_q == scec_pkg::obs_gap_st) && (cnt_q == 16'h0000);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_rx_q   <= scec_pkg::receive_side_off;
      req_tx_q   <= scec_pkg::transmit_side_off;
      auto_off_q <= 1'b0;
    end else if (clk_en && wr_chsel && chsel_ok) begin
      req_rx_q   <= scec_pkg::scec_rx_sel_t'(sw_wdata[2:0]);
      req_tx_q   <= scec_pkg::scec_tx_sel_t'(sw_wdata[4:3]);
      auto_off_q <= sw_wdata[`SCEC_CHSEL_AUTO_OFF];
    end
  end

  // refused commands never reach the link; set beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (clk_en) begin
      if ((wr_chsel && !chsel_ok) || (wr_pin && !pin_ok)) begin
        err_q <= 1'b1;
      end else if (sw_wr && (sw_addr == `SCEC_ADDR_STATUS) && sw_wdata[`SCEC_STATUS_ERR]) begin
        err_q <= 1'b0;
      end
    end
  end

  // observation release: after a hold, drop to receive off for a gap, then restore
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= scec_pkg::obs_idle_st;
      cnt_q   <= 16'h0000;
    end else if (clk_en) begin
      if (wr_chsel && chsel_ok) begin
        state_q <= new_obs ? scec_pkg::obs_hold_st : scec_pkg::obs_idle_st;
        cnt_q   <= 16'(HOLD_CYCLES - 1);
      end else begin
        case (state_q)
          scec_pkg::obs_hold_st: begin
            if (hold_done) begin
              state_q <= scec_pkg::obs_gap_st;
              cnt_q   <= 16'(GAP_CYCLES - 1);
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          scec_pkg::obs_gap_st: begin
            if (gap_done) begin
              state_q <= scec_pkg::obs_hold_st;
              cnt_q   <= 16'(HOLD_CYCLES - 1);
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          default: begin
            state_q <= scec_pkg::obs_idle_st;
          end
        endcase
      end
    end
  end

  // channel-select commands: software write first, then release and restore
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link.chsel_valid <= 1'b0;
      link.cmd_rx_sel  <= scec_pkg::receive_side_off;
      link.cmd_tx_sel  <= scec_pkg::transmit_side_off;
    end else if (clk_en) begin
      link.chsel_valid <= 1'b0;
      if (wr_chsel && chsel_ok) begin
        link.chsel_valid <= 1'b1;
        link.cmd_rx_sel  <= scec_pkg::scec_rx_sel_t'(sw_wdata[2:0]);
        link.cmd_tx_sel  <= scec_pkg::scec_tx_sel_t'(sw_wdata[4:3]);
      end else if (hold_done) begin
        link.chsel_valid <= 1'b1;
        link.cmd_rx_sel  <= scec_pkg::receive_side_off;
        link.cmd_tx_sel  <= req_tx_q;
      end else if (gap_done) begin
        link.chsel_valid <= 1'b1;
        link.cmd_rx_sel  <= req_rx_q;
        link.cmd_tx_sel  <= req_tx_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link.pinmode_valid           <= 1'b0;
      link.pin_options_setting     <= `SCEC_PIN_OPTIONS_RESET;
      link.obs_gpio_pair_selection <= scec_pkg::obs_gpio_pair_none;
    end else if (clk_en) begin
      link.pinmode_valid <= wr_pin && pin_ok;
      if (wr_pin && pin_ok) begin
        link.pin_options_setting     <= sw_wdata[7:0];
        link.obs_gpio_pair_selection <= scec_pkg::scec_gpio_pair_t'(sw_wdata[`SCEC_PINMODE_PAIR_LSB+:2]);
      end
    end
  end

  // pin levels, for time-aligned switching without the command path
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      drive_q <= 6'h00;
      gpio_q  <= 10'h000;
    end else if (clk_en && sw_wr) begin
      if (sw_addr == `SCEC_ADDR_DRIVE) begin
        drive_q <= sw_wdata[5:0];
      end
      if (sw_addr == `SCEC_ADDR_GPIO) begin
        gpio_q <= sw_wdata[9:0];
      end
    end
  end

  always_comb begin
    link.receiver_one_enable_in    = drive_q[`SCEC_CHAIN_RX1];
    link.receiver_two_enable_in    = drive_q[`SCEC_CHAIN_RX2];
    link.transmitter_one_enable_in = drive_q[`SCEC_CHAIN_TX1];
    link.transmitter_two_enable_in = drive_q[`SCEC_CHAIN_TX2];
    link.observation_one_enable_in = drive_q[`SCEC_CHAIN_OBS1];
    link.observation_two_enable_in = drive_q[`SCEC_CHAIN_OBS2];
    link.gpio_in                   = gpio_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sw_rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      sw_rdata_q <= 32'h0000_0000;
      if (sw_rd) begin
        case (sw_addr)
          `SCEC_ADDR_CHSEL: begin
            sw_rdata_q <= {23'h0, auto_off_q, 3'h0, req_tx_q, req_rx_q};
          end
          `SCEC_ADDR_PINMODE: begin
            sw_rdata_q <= {22'h0, link.obs_gpio_pair_selection, link.pin_options_setting};
          end
          `SCEC_ADDR_DRIVE: begin
            sw_rdata_q <= {26'h0, drive_q};
          end
          `SCEC_ADDR_GPIO: begin
            sw_rdata_q <= {22'h0, gpio_q};
          end
          `SCEC_ADDR_STATUS: begin
            sw_rdata_q <= {25'h0, state_q, 3'h0, err_q};
          end
          default: begin
            sw_rdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- bench/scec_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module scec_monitor (
  // clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst_n,
  // link between the two ends
  input wire logic                      chsel_valid,
  input wire scec_pkg::scec_rx_sel_t    cmd_rx_sel,
  input wire logic                      pinmode_valid,
  input wire logic [7:0]                pin_options_setting,
  input wire scec_pkg::scec_gpio_pair_t obs_gpio_pair_selection,
  input wire logic                      transmitter_one_enable_in,
  input wire logic                      observation_one_enable_in,
  input wire logic                      observation_two_enable_in,
  input wire logic [9:0]                gpio_in,
  // device state
  input wire logic [5:0]                chain_on_q,
  input wire scec_pkg::scec_rx_sel_t    rx_sel_q,
  input wire scec_pkg::scec_tx_sel_t    tx_sel_q,
  input wire logic [7:0]                pin_options_q,
  input wire scec_pkg::scec_gpio_pair_t gpio_pair_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // observation chains asked for by the receive-side select
  function automatic logic [1:0] obs_of(input logic [2:0] s);
    return {s == 3'h5 || s == 3'h6, s == 3'h4 || s == 3'h6};
  endfunction

  a_chsel_load: assert property (chsel_valid |=> rx_sel_q == $past(cmd_rx_sel))
    else $error("channel select not loaded");
  a_select_hold: assert property (!chsel_valid |=> $stable(rx_sel_q) && $stable(tx_sel_q))
    else $error("channel select changed without command");
  a_pinmode_load: assert property (pinmode_valid |=> pin_options_q == $past(pin_options_setting)
    && gpio_pair_q == $past(obs_gpio_pair_selection))
    else $error("pin mode not loaded");
  a_sw_rxtx_chains: assert property (!$past(pin_options_q[0]) |-> chain_on_q[3:0] ==
    {$past(tx_sel_q), ($past(rx_sel_q) < 3'h4) ? 2'($past(rx_sel_q)) : 2'h0})
    else $error("software rx or tx chains wrong");
  a_pin_tx_follow: assert property ($past(pin_options_q[0]) |->
    chain_on_q[2] == $past(transmitter_one_enable_in))
    else $error("tx chain does not follow its pin");
  a_sw_obs_chains: assert property (($past(pin_options_q) & 8'h16) == 8'h00 |->
    chain_on_q[5:4] == obs_of($past(rx_sel_q)))
    else $error("software observation chains wrong");
  a_gpio_obs_pair: assert property ($past(pin_options_q[1]) && ($past(pin_options_q) & 8'h14) == 8'h00
    && $past(gpio_pair_q) != scec_pkg::obs_gpio_pair_none
    |-> chain_on_q[5:4] == 2'($past(gpio_in) >> (4'h4 * $past(gpio_pair_q))))
    else $error("observation chains do not follow gpio pair");
  a_single_obs_gate: assert property (($past(pin_options_q) & 8'h16) == 8'h12
    && $past(gpio_pair_q) == scec_pkg::obs_gpio_pair_none
    |-> chain_on_q[5:4] == (($past(pin_options_q[5]) ? $past(observation_two_enable_in)
    : $past(observation_one_enable_in)) ? ($past(pin_options_q[3]) ? 2'h2 : 2'h1) : 2'h0))
    else $error("single observation gate wrong");

  c_obs_request: cover property (chsel_valid && cmd_rx_sel == scec_pkg::obs_one);
  c_single_mode: cover property (pinmode_valid && pin_options_setting[4]);
  c_obs_release: cover property (chain_on_q[4] ##1 !chain_on_q[4]);
endmodule
`default_nettype wire

// ---- bench/signal_chain_enable_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module signal_chain_enable_control_test;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [31:0] sw_rdata_q;
  logic [31:0] rdata_rx;
  logic [5:0]  chain_on_q;
  logic        obs_path_sel_q;
  logic [7:0]  pin_options_q;
  logic [31:0] d;
  int          fails = 0;
  int          num_checks = 0;
  int          k;
  scec_pkg::scec_rx_sel_t    rx_sel_q;
  scec_pkg::scec_tx_sel_t    tx_sel_q;
  scec_pkg::scec_gpio_pair_t gpio_pair_q;
  typedef struct {logic [31:0] cmd; logic [5:0] chains;} scec_row_t;
  scec_row_t rows [7] = '{'{32'h00, 6'h00}, '{32'h09, 6'h05}, '{32'h12, 6'h0a}, '{32'h1b, 6'h0f},
                          '{32'h04, 6'h10}, '{32'h0d, 6'h24}, '{32'h16, 6'h38}};

  always #50 core_clk = ~core_clk;

  scec_if lk ();
  scec_host #(.HOLD_CYCLES(8), .GAP_CYCLES(4)) i_scec_host (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata_q(sw_rdata_q), .link(lk));
  // a receive-only controller sees the same writes; only its status is read
  scec_if lk_rx ();
  scec_host #(.VARIANT(scec_pkg::variant_rx_only)) i_scec_host_rx (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata_q(rdata_rx), .link(lk_rx));
  scec_device i_scec_device (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .link(lk),
    .chain_on_q(chain_on_q), .obs_path_sel_q(obs_path_sel_q), .rx_sel_q(rx_sel_q),
    .tx_sel_q(tx_sel_q), .pin_options_q(pin_options_q), .gpio_pair_q(gpio_pair_q));
  scec_monitor i_scec_monitor (.core_clk(core_clk), .rst_n(rst_n), .chsel_valid(lk.chsel_valid),
    .cmd_rx_sel(lk.cmd_rx_sel), .pinmode_valid(lk.pinmode_valid),
    .pin_options_setting(lk.pin_options_setting), .obs_gpio_pair_selection(lk.obs_gpio_pair_selection),
    .transmitter_one_enable_in(lk.transmitter_one_enable_in),
    .observation_one_enable_in(lk.observation_one_enable_in),
    .observation_two_enable_in(lk.observation_two_enable_in), .gpio_in(lk.gpio_in),
    .chain_on_q(chain_on_q), .rx_sel_q(rx_sel_q), .tx_sel_q(tx_sel_q),
    .pin_options_q(pin_options_q), .gpio_pair_q(gpio_pair_q));

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata_q;
  endtask

  // a command reaches the chains two edges after its write edge
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_obs(input logic v, output int n);
    n = 0;
    while (chain_on_q[4] !== v && n < 30) begin
      settle(1);
      n++;
    end
  endtask

  task automatic reset_check;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    `CHK("chains", 6'h00, chain_on_q)
    `CHK("opts", 8'h00, pin_options_q)
    `CHK("pair", scec_pkg::obs_gpio_pair_none, gpio_pair_q)
  endtask

  task automatic summarize;
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    reset_check();
    rd(4'h4, d);
    `CHK("status", 32'h10, d)
    rd(4'hf, d);
    `CHK("unmapped", 32'h0, d)
    foreach (rows[i]) begin
      wr(4'h0, rows[i].cmd);
      settle(3);
      `CHK("chains", rows[i].chains, chain_on_q)
      `CHK("rx_sel", rows[i].cmd[2:0], rx_sel_q)
      `CHK("tx_sel", rows[i].cmd[4:3], tx_sel_q)
    end
    settle(40);
    `CHK("held", 6'h38, chain_on_q)
    // pins override the standing software select
    wr(4'h2, 32'h0f);
    for (k = 0; k < 3; k++) begin
      wr(4'h1, 32'h003 | (k << 8));
      wr(4'h3, 32'h1 << (4 * k));
      settle(3);
      `CHK("pin chains", 6'h1f, chain_on_q)
    end
    wr(4'h2, 32'h05);
    wr(4'h3, 32'h200);
    settle(3);
    `CHK("pin low", 6'h25, chain_on_q)
    wr(4'h1, 32'h302);
    wr(4'h2, 32'h20);
    settle(3);
    `CHK("obs pins", 6'h28, chain_on_q)
    for (k = 0; k < 4; k++) begin
      wr(4'h1, 32'h312 + 32'(k % 2) * 8 + 32'(k / 2) * 32);
      wr(4'h2, (k / 2) ? 32'h20 : 32'h10);
      settle(3);
      `CHK("single", {(k % 2) ? 2'h2 : 2'h1, 4'h8}, chain_on_q)
      `CHK("path sel", 1'(k % 2), obs_path_sel_q)
      wr(4'h2, (k / 2) ? 32'h10 : 32'h20);
      settle(3);
      `CHK("single off", 6'h08, chain_on_q)
    end
    // shares-rx on the full variant and an out-of-range select are both refused
    wr(4'h1, 32'h304);
    wr(4'h0, 32'h07);
    settle(3);
    `CHK("refused opts", 8'h3a, pin_options_q)
    `CHK("refused sel", scec_pkg::obs_both, rx_sel_q)
    rd(4'h4, d);
    `CHK("err", 32'h11, d)
    wr(4'h4, 32'h1);
    rd(4'h4, d);
    `CHK("err clear", 32'h10, d)
    wr(4'h1, 32'h300);
    wr(4'h0, 32'h104);
    settle(3);
    `CHK("obs on", 6'h10, chain_on_q)
    wait_obs(1'b0, k);
    `CHK("released", 6'h00, chain_on_q)
    // the chain had been on for one edge already at the first look
    `CHK("hold len", 8 - 1, k)
    wait_obs(1'b1, k);
    `CHK("renewed", 6'h10, chain_on_q)
    `CHK("gap len", 4, k)
    // clock enable low freezes both ends: no release, no register write
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(4'h2, 32'h3f);
    settle(20);
    `CHK("frozen", 6'h10, chain_on_q)
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(4'h2, d);
    `CHK("frozen drive", 32'h10, d)
    rd(4'h4, d);
    `CHK("status", 32'h20, d)
    `CHK("rx-only obs", 32'h11, rdata_rx)
    wr(4'h4, 32'h1);
    wr(4'h1, 32'h003);
    rd(4'h4, d);
    `CHK("rx-only pair", 32'h11, rdata_rx)
    @(posedge core_clk);
    rst_n <= 1'b0;
    reset_check();
    rd(4'h4, d);
    `CHK("status", 32'h10, d)
    summarize();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge core_clk);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
